// ---- flb_cfg_source.sv ----
// model of the configuring party: breakpoint table of the curve block
// assumes the bench writes each point it hands out over the register port
`timescale 1ns/100ps
module flb_cfg_source (
  input wire logic [4:0] i_point,
  output logic [31:0] o_absc,
  output logic [31:0] o_ordn
);
  // two used points, unused points padded with the last used one, abscissas ascending
  always_comb begin
    o_absc = (i_point == 5'h00) ? 32'h0 : 32'h64;
    o_ordn = (i_point == 5'h00) ? 32'h0 : 32'h3e8;
  end
endmodule

// ---- flb_consts.svh ----
// constants for the free logic timer block library: timing, addresses, fields
// assumes a single 100 MHz clock and word addressing on the register port
`ifndef FLB_CONSTS_SVH
`define FLB_CONSTS_SVH

// clock and time slice
`define FLB_CLK_HZ 100000000
`define FLB_SLICE_MS 8
`define FLB_SLICE_CYCLES (`FLB_SLICE_MS * `FLB_CLK_HZ / 1000)
`define FLB_NUM_GROUPS 6
`define FLB_SEQ_MAX 15'h7d00

// numeric range: symmetric saturation limit of the number format
`define FLB_NUM_MAX 32'h7fffffff
`define FLB_NUM_MIN 32'h80000001

// block indices
`define FLB_NUM_BLOCKS 14
`define FLB_BLK_PGEN 0
`define FLB_BLK_PLIM 1
`define FLB_BLK_OND 2
`define FLB_BLK_OFFD 3
`define FLB_BLK_EXT 4
`define FLB_BLK_MUL 5
`define FLB_BLK_SUB 6
`define FLB_BLK_CMP 7
`define FLB_BLK_SEL 8
`define FLB_BLK_INV 9
`define FLB_BLK_OR 10
`define FLB_BLK_CURVE 11
`define FLB_BLK_SMOOTH 12
`define FLB_BLK_LATCH 13
`define FLB_NUM_TIMERS 5
`define FLB_TDUR_SMOOTH 5

// curve memory
`define FLB_CURVE_POINTS 20
`define FLB_CURVE_WORDS 40

// register word addresses
`define FLB_ADDR_CFG 8'h00
`define FLB_ADDR_TDUR 8'h10
`define FLB_ADDR_FLAGS 8'h18
`define FLB_ADDR_MUL 8'h19
`define FLB_ADDR_SUB 8'h1a
`define FLB_ADDR_SEL 8'h1b
`define FLB_ADDR_CURVE 8'h1c
`define FLB_ADDR_SMOOTH 8'h1d
`define FLB_ADDR_CURVE_MEM 8'h40

// block config fields
`define FLB_CFG_GRP_LSB 0
`define FLB_CFG_GRP_MSB 2
`define FLB_CFG_SEQ_LSB 16
`define FLB_CFG_SEQ_MSB 30

`endif

// ---- flb_curve_mem.sv ----
// breakpoint memory of the curve block: 20 abscissa/ordinate pairs
// assumes reads are one cycle late, data taken from a register
`timescale 1ns/100ps
module flb_curve_mem (
  input wire logic i_clk,
  input wire logic i_reset_n,
  flb_mem_if.mem mport
);
  flb_pkg::flb_mem_state_t state_reg;
  flb_pkg::flb_mem_state_t state_next;

  // write port and registered read port
  always_comb begin
    state_next = state_reg;
    if (mport.we && (mport.waddr < 6'(`FLB_CURVE_WORDS))) begin
      state_next.words[mport.waddr] = mport.wdata;
    end
    if (mport.raddr < 6'(`FLB_CURVE_WORDS)) begin
      state_next.rdata = state_reg.words[mport.raddr];
    end else begin
      state_next.rdata = 32'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign mport.rdata = state_reg.rdata;
endmodule

// ---- flb_mem_if.sv ----
// write and read port between the block scheduler and the curve memory
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface flb_mem_if;
  logic we;
  logic [5:0] waddr;
  logic [31:0] wdata;
  logic [5:0] raddr;
  logic [31:0] rdata;
  modport ctrl(output we, output waddr, output wdata, output raddr, input rdata);
  modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ---- flb_pkg.sv ----
// types of the free logic timer block library
// assumes flb_consts.svh is on the include path
package flb_pkg;
`include "flb_consts.svh"

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SCAN = 5'h02,
    ST_CRA = 5'h04,
    ST_CRB = 5'h08,
    ST_CCK = 5'h10
  } flb_state_t;

  typedef struct packed {
    flb_state_t st;
    logic [14:0] seq;
    logic [5:0] grp_due;
    logic [31:0] tick_cnt;
    logic [4:0] tick_idx;
    logic [13:0][31:0] cfg;
    logic [5:0][31:0] tdur;
    logic [4:0] prev;
    logic [4:0][31:0] elapsed;
    logic [4:0] tq;
    logic [31:0] mul_y, sub_y, sel_y, curve_y, smooth_y;
    logic above, equal, below, inv_q, or_q, latch_q, latch_qn;
    logic [4:0] ck;
    logic [31:0] cx, pa, pb, acur;
    logic [31:0] rdata;
  } flb_top_state_t;

  typedef struct packed {
    logic [39:0][31:0] words;
    logic [31:0] rdata;
  } flb_mem_state_t;

endpackage

// ---- flb_top.sv ----
// free logic timer blocks: timers, arithmetic, compare, curve, smoother, latch
// assumes inputs synchronous to i_clk and a one-cycle strobed register port
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "flb_consts.svh"

// Contract
// - pulse generator output high for the set duration after a trigger rise
// - pulse generator ignores further rises while its pulse is running
// - multiplier outputs product of four inputs, saturated symmetrically
// - subtracter outputs first minus second input, saturated symmetrically
// - comparator raises exactly one of above, equal and below
// - inverter outputs the complement of its input
// - selector passes first value on low select, second on high
// - four-input or is low only when all inputs are low
// - pulse limiter rises on input rise, falls on low input or timeout
// - on delay rises after delay from input rise, low whenever input low
// - off delay high with input, falls after delay unless input returns
// - curve interpolates over 20 points, flat outside first and last
// - pulse extender rises on input rise, falls when input low and timed out
// - smoother follows input with first-order lag, preset while set high
// - reset dominant latch with a complement output
// - blocks run in six groups with periods 8 ms doubling to 256 ms
// - within a group blocks run in ascending sequence number 0 to 32000
module flb_top #(
  parameter int TICK_CYCLES = `FLB_SLICE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_pgen_trig,
  input wire logic i_plim_in,
  input wire logic i_ond_in,
  input wire logic i_offd_in,
  input wire logic i_ext_in,
  input wire logic i_ext_rst,
  input wire logic [31:0] i_mul_x0,
  input wire logic [31:0] i_mul_x1,
  input wire logic [31:0] i_mul_x2,
  input wire logic [31:0] i_mul_x3,
  input wire logic [31:0] i_sub_x0,
  input wire logic [31:0] i_sub_x1,
  input wire logic [31:0] i_cmp_x0,
  input wire logic [31:0] i_cmp_x1,
  input wire logic [31:0] i_sel_x0,
  input wire logic [31:0] i_sel_x1,
  input wire logic i_sel_bit,
  input wire logic i_inv_in,
  input wire logic [3:0] i_or_in,
  input wire logic [31:0] i_curve_x,
  input wire logic [31:0] i_smooth_x,
  input wire logic [31:0] i_smooth_preset_value,
  input wire logic i_smooth_set,
  input wire logic i_latch_set,
  input wire logic i_latch_rst,
  output logic o_pgen_q,
  output logic o_plim_q,
  output logic o_ond_q,
  output logic o_offd_q,
  output logic o_ext_q,
  output logic [31:0] o_mul_y,
  output logic [31:0] o_sub_y,
  output logic o_cmp_above_flag,
  output logic o_cmp_equal_flag,
  output logic o_cmp_below_flag,
  output logic [31:0] o_sel_y,
  output logic o_inv_q,
  output logic o_or_q,
  output logic [31:0] o_curve_y,
  output logic [31:0] o_smooth_y,
  output logic o_latch_q,
  output logic o_latch_inverted_output
);
  flb_pkg::flb_top_state_t state_reg;
  flb_pkg::flb_top_state_t state_next;
  logic [`FLB_NUM_BLOCKS-1:0] due;
  logic [`FLB_NUM_BLOCKS-1:0][31:0] slice_ms;
  logic [4:0] tin;
  logic [4:0] rise;
  logic [12:0] flags;
  logic signed [127:0] mul_full;
  logic signed [127:0] sub_full;
  logic signed [65:0] crv_quo;
  logic signed [65:0] smo_quo;
  logic mem_sel;

  flb_mem_if mif();

  flb_curve_mem u_mem (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .mport(mif.mem)
  );

  // saturate a wide signed value to the symmetric numeric range
  function automatic logic [31:0] sat(input logic signed [127:0] v);
    if (v > $signed({96'h0, `FLB_NUM_MAX})) begin
      return `FLB_NUM_MAX;
    end else if (v < -$signed({96'h0, `FLB_NUM_MAX})) begin
      return `FLB_NUM_MIN;
    end
    return v[31:0];
  endfunction

  // advance elapsed time by one slice, stop once the duration is reached
  function automatic logic [31:0] adv(input logic [31:0] el, input logic [31:0] sl,
                                      input logic [31:0] t);
    if (el >= t) begin
      return el;
    end
    return el + sl;
  endfunction

  // due strobe and slice length of each block from its group and sequence
  for (genvar i = 0; i < `FLB_NUM_BLOCKS; i++) begin : g_due
    logic [2:0] grp;
    assign grp = state_reg.cfg[i][`FLB_CFG_GRP_MSB:`FLB_CFG_GRP_LSB];
    assign due[i] = (state_reg.st == flb_pkg::ST_SCAN) && (grp != 3'h0) &&
                    (grp <= 3'(`FLB_NUM_GROUPS)) && state_reg.grp_due[grp - 3'h1] &&
                    (state_reg.cfg[i][`FLB_CFG_SEQ_MSB:`FLB_CFG_SEQ_LSB] ==
                     state_reg.seq);
    assign slice_ms[i] = (grp == 3'h0) ? 32'h0 : (32'(`FLB_SLICE_MS) << (grp - 3'h1));
  end

  // timer inputs and their edges against the last evaluation
  assign tin = {i_ext_in, i_offd_in, i_ond_in, i_plim_in, i_pgen_trig};
  assign rise = tin & ~state_reg.prev;

  // wide arithmetic shared by the value blocks
  assign mul_full = 128'($signed(i_mul_x0)) * 128'($signed(i_mul_x1)) *
                    128'($signed(i_mul_x2)) * 128'($signed(i_mul_x3));
  assign sub_full = 128'($signed(i_sub_x0)) - 128'($signed(i_sub_x1));
  assign crv_quo = (66'($signed(state_reg.cx)) - 66'($signed(state_reg.pa))) *
                   (66'($signed(mif.rdata)) - 66'($signed(state_reg.pb))) /
                   (66'($signed(state_reg.acur)) - 66'($signed(state_reg.pa)));
  assign smo_quo = (66'($signed(i_smooth_x)) - 66'($signed(state_reg.smooth_y))) *
                   $signed(66'(slice_ms[`FLB_BLK_SMOOTH])) /
                   $signed(66'(state_reg.tdur[`FLB_TDUR_SMOOTH]) +
                           66'(slice_ms[`FLB_BLK_SMOOTH]));

  // curve memory port: bus writes in, breakpoint walk reads out
  assign mem_sel = (i_addr >= `FLB_ADDR_CURVE_MEM) &&
                   (i_addr < (`FLB_ADDR_CURVE_MEM + 8'(`FLB_CURVE_WORDS)));
  assign mif.we = i_wr && mem_sel;
  assign mif.waddr = 6'(i_addr - `FLB_ADDR_CURVE_MEM);
  assign mif.wdata = i_wdata;
  assign mif.raddr = {state_reg.ck, (state_reg.st == flb_pkg::ST_CRB)};

  // readable block outputs
  assign flags = {(state_reg.st != flb_pkg::ST_IDLE), state_reg.latch_qn, state_reg.latch_q,
                  state_reg.or_q, state_reg.inv_q, state_reg.below, state_reg.equal,
                  state_reg.above, state_reg.tq};

  // scheduler, block evaluation and register port
  always_comb begin
    state_next = state_reg;
    state_next.rdata = 32'h0;
    // base slice tick and group due mask
    if (state_reg.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      state_next.tick_cnt = 32'h0;
      state_next.tick_idx = state_reg.tick_idx + 5'h1;
      if (state_reg.st == flb_pkg::ST_IDLE) begin
        for (int g = 0; g < `FLB_NUM_GROUPS; g++) begin
          state_next.grp_due[g] = ((state_reg.tick_idx & 5'((1 << g) - 1)) == 5'h0);
        end
        state_next.seq = 15'h0;
        state_next.st = flb_pkg::ST_SCAN;
      end
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + 32'h1;
    end
    // timers: remember the input of each evaluation
    for (int t = 0; t < `FLB_NUM_TIMERS; t++) begin
      if (due[t]) begin
        state_next.prev[t] = tin[t];
      end
    end
    // pulse generator: fixed length, not retriggerable
    if (due[`FLB_BLK_PGEN]) begin
      if (!state_reg.tq[0]) begin
        if (rise[0]) begin
          state_next.tq[0] = 1'b1;
          state_next.elapsed[0] = 32'h0;
        end
      end else begin
        state_next.elapsed[0] = adv(state_reg.elapsed[0], slice_ms[0],
                                    state_reg.tdur[0]);
        if (state_next.elapsed[0] >= state_reg.tdur[0]) begin
          state_next.tq[0] = 1'b0;
        end
      end
    end
    // pulse limiter
    if (due[`FLB_BLK_PLIM]) begin
      if (!tin[1]) begin
        state_next.tq[1] = 1'b0;
      end else if (rise[1]) begin
        state_next.tq[1] = 1'b1;
        state_next.elapsed[1] = 32'h0;
      end else if (state_reg.tq[1]) begin
        state_next.elapsed[1] = adv(state_reg.elapsed[1], slice_ms[1], state_reg.tdur[1]);
        if (state_next.elapsed[1] >= state_reg.tdur[1]) begin
          state_next.tq[1] = 1'b0;
        end
      end
    end
    // on delay
    if (due[`FLB_BLK_OND]) begin
      if (!tin[2]) begin
        state_next.tq[2] = 1'b0;
        state_next.elapsed[2] = 32'h0;
      end else begin
        state_next.elapsed[2] = rise[2] ? 32'h0 :
                                adv(state_reg.elapsed[2], slice_ms[2], state_reg.tdur[2]);
        state_next.tq[2] = (state_next.elapsed[2] >= state_reg.tdur[2]);
      end
    end
    // off delay
    if (due[`FLB_BLK_OFFD]) begin
      if (tin[3]) begin
        state_next.tq[3] = 1'b1;
        state_next.elapsed[3] = 32'h0;
      end else if (state_reg.tq[3]) begin
        state_next.elapsed[3] = adv(state_reg.elapsed[3], slice_ms[3], state_reg.tdur[3]);
        if (state_next.elapsed[3] >= state_reg.tdur[3]) begin
          state_next.tq[3] = 1'b0;
        end
      end
    end
    // pulse extender with dominant reset
    if (due[`FLB_BLK_EXT]) begin
      if (i_ext_rst) begin
        state_next.tq[4] = 1'b0;
      end else if (rise[4]) begin
        state_next.tq[4] = 1'b1;
        state_next.elapsed[4] = 32'h0;
      end else if (state_reg.tq[4]) begin
        state_next.elapsed[4] = adv(state_reg.elapsed[4], slice_ms[4], state_reg.tdur[4]);
        if (!tin[4] && (state_next.elapsed[4] >= state_reg.tdur[4])) begin
          state_next.tq[4] = 1'b0;
        end
      end
    end
    // value blocks
    if (due[`FLB_BLK_MUL]) begin
      state_next.mul_y = sat(mul_full);
    end
    if (due[`FLB_BLK_SUB]) begin
      state_next.sub_y = sat(sub_full);
    end
    if (due[`FLB_BLK_CMP]) begin
      state_next.above = ($signed(i_cmp_x0) > $signed(i_cmp_x1));
      state_next.equal = (i_cmp_x0 == i_cmp_x1);
      state_next.below = ($signed(i_cmp_x0) < $signed(i_cmp_x1));
    end
    if (due[`FLB_BLK_SEL]) begin
      state_next.sel_y = i_sel_bit ? i_sel_x1 : i_sel_x0;
    end
    if (due[`FLB_BLK_INV]) begin
      state_next.inv_q = ~i_inv_in;
    end
    if (due[`FLB_BLK_OR]) begin
      state_next.or_q = |i_or_in;
    end
    if (due[`FLB_BLK_SMOOTH]) begin
      state_next.smooth_y = i_smooth_set ? i_smooth_preset_value :
                            state_reg.smooth_y + smo_quo[31:0];
    end
    if (due[`FLB_BLK_LATCH]) begin
      if (i_latch_rst) begin
        state_next.latch_q = 1'b0;
        state_next.latch_qn = 1'b1;
      end else if (i_latch_set) begin
        state_next.latch_q = 1'b1;
        state_next.latch_qn = 1'b0;
      end
    end
    // sequence walk and breakpoint walk of the curve
    unique case (state_reg.st)
      flb_pkg::ST_IDLE: begin
      end
      flb_pkg::ST_SCAN: begin
        if (due[`FLB_BLK_CURVE]) begin
          state_next.ck = 5'h0;
          state_next.cx = i_curve_x;
          state_next.st = flb_pkg::ST_CRA;
        end else if (state_reg.seq >= `FLB_SEQ_MAX) begin
          state_next.st = flb_pkg::ST_IDLE;
        end else begin
          state_next.seq = state_reg.seq + 15'h1;
        end
      end
      flb_pkg::ST_CRA: begin
        state_next.st = flb_pkg::ST_CRB;
      end
      flb_pkg::ST_CRB: begin
        state_next.acur = mif.rdata;
        state_next.st = flb_pkg::ST_CCK;
      end
      flb_pkg::ST_CCK: begin
        state_next.st = flb_pkg::ST_CRA;
        if ($signed(state_reg.cx) <= $signed(state_reg.acur) ||
            (state_reg.ck == 5'(`FLB_CURVE_POINTS - 1))) begin
          // flat before the first and after the last point, linear between
          if ((state_reg.ck == 5'h0) || ($signed(state_reg.cx) > $signed(state_reg.acur))) begin
            state_next.curve_y = mif.rdata;
          end else begin
            state_next.curve_y = state_reg.pb + crv_quo[31:0];
          end
          if (state_reg.seq >= `FLB_SEQ_MAX) begin
            state_next.st = flb_pkg::ST_IDLE;
          end else begin
            state_next.seq = state_reg.seq + 15'h1;
            state_next.st = flb_pkg::ST_SCAN;
          end
        end else begin
          state_next.pa = state_reg.acur;
          state_next.pb = mif.rdata;
          state_next.ck = state_reg.ck + 5'h1;
        end
      end
      default: begin
        state_next.st = flb_pkg::ST_IDLE;
      end
    endcase
    // register writes
    if (i_wr) begin
      if (i_addr < (`FLB_ADDR_CFG + 8'(`FLB_NUM_BLOCKS))) begin
        state_next.cfg[4'(i_addr)] = i_wdata;
      end else if ((i_addr >= `FLB_ADDR_TDUR) && (i_addr < `FLB_ADDR_TDUR + 8'h6)) begin
        state_next.tdur[3'(i_addr - `FLB_ADDR_TDUR)] = i_wdata;
      end
    end
    // register reads, data in the next cycle only
    if (i_rd) begin
      if (i_addr < (`FLB_ADDR_CFG + 8'(`FLB_NUM_BLOCKS))) begin
        state_next.rdata = state_reg.cfg[4'(i_addr)];
      end else if ((i_addr >= `FLB_ADDR_TDUR) && (i_addr < `FLB_ADDR_TDUR + 8'h6)) begin
        state_next.rdata = state_reg.tdur[3'(i_addr - `FLB_ADDR_TDUR)];
      end else if (i_addr == `FLB_ADDR_FLAGS) begin
        state_next.rdata = {19'h0, flags};
      end else if (i_addr == `FLB_ADDR_MUL) begin
        state_next.rdata = state_reg.mul_y;
      end else if (i_addr == `FLB_ADDR_SUB) begin
        state_next.rdata = state_reg.sub_y;
      end else if (i_addr == `FLB_ADDR_SEL) begin
        state_next.rdata = state_reg.sel_y;
      end else if (i_addr == `FLB_ADDR_CURVE) begin
        state_next.rdata = state_reg.curve_y;
      end else if (i_addr == `FLB_ADDR_SMOOTH) begin
        state_next.rdata = state_reg.smooth_y;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= '0;
      state_reg.st <= flb_pkg::ST_IDLE;
      state_reg.latch_qn <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign o_rdata = state_reg.rdata;
  assign o_pgen_q = state_reg.tq[0];
  assign o_plim_q = state_reg.tq[1];
  assign o_ond_q = state_reg.tq[2];
  assign o_offd_q = state_reg.tq[3];
  assign o_ext_q = state_reg.tq[4];
  assign o_mul_y = state_reg.mul_y;
  assign o_sub_y = state_reg.sub_y;
  assign o_cmp_above_flag = state_reg.above;
  assign o_cmp_equal_flag = state_reg.equal;
  assign o_cmp_below_flag = state_reg.below;
  assign o_sel_y = state_reg.sel_y;
  assign o_inv_q = state_reg.inv_q;
  assign o_or_q = state_reg.or_q;
  assign o_curve_y = state_reg.curve_y;
  assign o_smooth_y = state_reg.smooth_y;
  assign o_latch_q = state_reg.latch_q;
  assign o_latch_inverted_output = state_reg.latch_qn;
endmodule

// ---- flb_top_asserts.sv ----
// checker for the free logic block top: bus idle data, latch, compare, saturation, timers
// assumes inputs held steady around each evaluation, as the bench does
`timescale 1ns/100ps
module flb_top_asserts (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_latch_q,
  input wire logic o_latch_inverted_output,
  input wire logic i_latch_set,
  input wire logic i_latch_rst,
  input wire logic o_cmp_above_flag,
  input wire logic o_cmp_equal_flag,
  input wire logic o_cmp_below_flag,
  input wire logic [31:0] o_mul_y,
  input wire logic [31:0] o_sub_y,
  input wire logic i_inv_in,
  input wire logic o_inv_q,
  input wire logic [3:0] i_or_in,
  input wire logic o_or_q,
  input wire logic i_sel_bit,
  input wire logic [31:0] i_sel_x0,
  input wire logic [31:0] i_sel_x1,
  input wire logic [31:0] o_sel_y,
  input wire logic i_ond_in,
  input wire logic o_ond_q,
  input wire logic i_offd_in,
  input wire logic o_offd_q,
  input wire logic i_plim_in,
  input wire logic o_plim_q
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // read data only in the cycle after a read strobe
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  latch_compl_a: assert property (o_latch_inverted_output == !o_latch_q)
    else $error("latch outputs not complementary");
  latch_set_a: assert property ($rose(o_latch_q) |-> $past(i_latch_set && !i_latch_rst))
    else $error("latch rose without lone set");
  cmp_onehot_a: assert property (
    $onehot0({o_cmp_above_flag, o_cmp_equal_flag, o_cmp_below_flag}))
    else $error("comparator shows more than one flag");
  mul_range_a: assert property (o_mul_y != 32'h80000000)
    else $error("product outside symmetric range");
  sub_range_a: assert property (o_sub_y != 32'h80000000)
    else $error("difference outside symmetric range");
  inv_val_a: assert property ($changed(o_inv_q) |-> o_inv_q == !$past(i_inv_in))
    else $error("inverter output not complement");
  or_val_a: assert property ($changed(o_or_q) |-> o_or_q == |$past(i_or_in))
    else $error("or output wrong");
  sel_val_a: assert property ($changed(o_sel_y) |->
    o_sel_y == ($past(i_sel_bit) ? $past(i_sel_x1) : $past(i_sel_x0)))
    else $error("selector passed wrong value");
  ond_rise_a: assert property ($rose(o_ond_q) |-> $past(i_ond_in))
    else $error("on delay rose with input low");
  offd_fall_a: assert property ($fell(o_offd_q) |-> !$past(i_offd_in))
    else $error("off delay fell with input high");
  plim_rise_a: assert property ($rose(o_plim_q) |-> $past(i_plim_in))
    else $error("pulse limiter rose with input low");
endmodule
bind flb_top flb_top_asserts chk_u (.i_clk, .i_reset_n, .i_rd, .o_rdata, .o_latch_q,
  .o_latch_inverted_output, .o_cmp_above_flag, .o_cmp_equal_flag, .o_cmp_below_flag,
  .o_mul_y, .o_sub_y, .i_inv_in, .o_inv_q, .i_or_in, .o_or_q, .i_sel_bit, .i_sel_x0,
  .i_sel_x1, .o_sel_y, .i_ond_in, .o_ond_q, .i_offd_in, .o_offd_q, .i_plim_in, .o_plim_q,
  .i_latch_set, .i_latch_rst);

// ---- testbench.sv ----
// self-checking bench of the free logic block top, three evaluation rows then hand tests
// assumes a scan outlasts one tick, so group 1 evaluates at every other tick
`timescale 1ns/100ps
module testbench;
  localparam int T = 16100; // ticks that fall inside a scan are refused
  typedef struct {
    logic [5:0] tin;
    logic [31:0] m0, m1, m2, s0, s1, c0, c1;
    logic sel, inv;
    logic [3:0] orin;
    logic [31:0] cx;
    logic sset;
    logic [1:0] lsr;
    logic [4:0] tq;
    logic [31:0] mul, sub;
    logic [2:0] cmp;
    logic [31:0] sy;
    logic iq, oq, lq;
    logic [31:0] cy, smy;
  } flb_row_t;
  flb_row_t rows[3];
  logic i_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0;
  logic [7:0] i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [5:0] tin = 6'h0;
  logic [31:0] m0 = 0, m1 = 0, m2 = 0, m3 = 0, s0 = 0, s1 = 0, c0 = 0, c1 = 0, cx = 0;
  logic sel = 0, inv = 0, sset = 0, lset = 0, lrst = 0;
  logic [3:0] orin = 4'h0;
  logic [4:0] pt = 5'h0;
  logic [31:0] absc, ordn, rdata, mul_y, sub_y, sel_y, curve_y, smooth_y;
  logic pq, lq_, oq, fq, eq, ca, ce, cb, iq, rq, tq, tqn;
  int failures = 0, samples_checked = 0, cyc = 0;
  flb_cfg_source src (.i_point(pt), .o_absc(absc), .o_ordn(ordn));
  flb_top #(.TICK_CYCLES(T)) dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_pgen_trig(tin[0]),
    .i_plim_in(tin[1]), .i_ond_in(tin[2]), .i_offd_in(tin[3]), .i_ext_in(tin[4]),
    .i_ext_rst(tin[5]), .i_mul_x0(m0), .i_mul_x1(m1), .i_mul_x2(m2), .i_mul_x3(m3),
    .i_sub_x0(s0), .i_sub_x1(s1), .i_cmp_x0(c0), .i_cmp_x1(c1), .i_sel_x0(32'hb),
    .i_sel_x1(32'h16), .i_sel_bit(sel), .i_inv_in(inv), .i_or_in(orin), .i_curve_x(cx),
    .i_smooth_x(32'h4b0), .i_smooth_preset_value(32'h190), .i_smooth_set(sset),
    .i_latch_set(lset), .i_latch_rst(lrst), .o_pgen_q(pq), .o_plim_q(lq_), .o_ond_q(oq),
    .o_offd_q(fq), .o_ext_q(eq), .o_mul_y(mul_y), .o_sub_y(sub_y), .o_cmp_above_flag(ca),
    .o_cmp_equal_flag(ce), .o_cmp_below_flag(cb), .o_sel_y(sel_y), .o_inv_q(iq),
    .o_or_q(rq), .o_curve_y(curve_y), .o_smooth_y(smooth_y), .o_latch_q(tq),
    .o_latch_inverted_output(tqn));
  // clock and cycle count since reset release
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (i_reset_n) cyc <= cyc + 1;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(name, rdata, exp);
  endtask
  task automatic wait_to(input int target);
    for (int n = 0; n < 200000 && cyc < target; n++) @(posedge i_clk);
    if (cyc < target) begin
      failures++;
      tally_and_finish();
    end
  endtask
  initial begin
    rows[0] = '{6'h1f, 2, 3, 4, 10, 3, 5, 3, 0, 0, 4'h0, 32'hfffffffb, 1, 2'b10,
      5'b11011, 32'h78, 32'h7, 3'b100, 32'hb, 1, 0, 1, 32'h0, 32'h190};
    rows[1] = '{6'h16, 32'h10000, 32'h10000, 1, 32'h7fffffff, 32'hffffffff, 32'hffffffff, 1,
      1, 1, 4'h8, 32'h32, 0, 2'b00, 5'b11101, 32'h7fffffff, 32'h7fffffff, 3'b001, 32'h16,
      0, 1, 1, 32'h1f4, 32'h258};
    rows[2] = '{6'h29, 32'hffff0000, 32'h10000, 1, 32'h80000001, 1, 7, 7, 0, 0, 4'h1,
      32'hc8, 0, 2'b11, 5'b01000, 32'h80000001, 32'h80000001, 3'b010, 32'hb, 1, 1, 0,
      32'h3e8, 32'h2ee};
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    // every block in group 1, durations 16/8/8/16/8 ms, smoother constant 24 ms
    for (int b = 0; b < 14; b++) wr(8'(b), 32'h1);
    wr(8'h10, 32'h10);
    wr(8'h11, 32'h8);
    wr(8'h12, 32'h8);
    wr(8'h13, 32'h10);
    wr(8'h14, 32'h8);
    wr(8'h15, 32'h18);
    for (int k = 0; k < 20; k++) begin
      pt = 5'(k);
      #1 wr(8'h40 + 8'(2 * k), absc);
      wr(8'h41 + 8'(2 * k), ordn);
    end
    rd("config", 8'h00, 32'h1);
    // one row per evaluation, evaluations at odd ticks, checks at even ticks
    for (int r = 0; r < 3; r++) begin
      wait_to(2 * r * T + 200);
      if (r > 0) begin
        chk("timers", {27'h0, eq, fq, oq, lq_, pq},
          {27'h0, rows[r - 1].tq});
        chk("mul", mul_y, rows[r - 1].mul);
        chk("sub", sub_y, rows[r - 1].sub);
        chk("cmp", {29'h0, ca, ce, cb}, {29'h0, rows[r - 1].cmp});
        chk("misc", {20'h0, sel_y[7:0], iq, rq, tq, tqn}, {20'h0, rows[r - 1].sy[7:0],
          rows[r - 1].iq, rows[r - 1].oq, rows[r - 1].lq, !rows[r - 1].lq});
        chk("curve", curve_y, rows[r - 1].cy);
        chk("smooth", smooth_y, rows[r - 1].smy);
      end
      {tin, m0, m1, m2, s0, s1, c0, c1} <= {rows[r].tin, rows[r].m0, rows[r].m1, rows[r].m2,
        rows[r].s0, rows[r].s1, rows[r].c0, rows[r].c1};
      {m3, sel, inv, orin, cx, sset, lset, lrst} <= {32'h1 + 32'(r == 0 ? 4 : 0), rows[r].sel,
        rows[r].inv, rows[r].orin, rows[r].cx, rows[r].sset, rows[r].lsr};
    end
    wait_to(6 * T + 200);
    chk("timers", {27'h0, eq, fq, oq, lq_, pq}, {27'h0, rows[2].tq});
    chk("mul", mul_y, rows[2].mul);
    chk("sub", sub_y, rows[2].sub);
    chk("cmp", {29'h0, ca, ce, cb}, {29'h0, rows[2].cmp});
    chk("latch", {30'h0, tq, tqn}, 32'h1);
    chk("curve", curve_y, rows[2].cy);
    chk("smooth", smooth_y, rows[2].smy);
    // register reads: flags mid-scan, result word, unmapped place, write-only memory
    rd("flags", 8'h18, 32'h1b48);
    rd("mul_reg", 8'h19, 32'h80000001);
    rd("unmapped", 8'h30, 32'h0);
    rd("curve_mem", 8'h40, 32'h0);
    // reset in mid-run clears outputs and configs, except the latch complement output, which goes high
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("rst_mul", mul_y, 32'h0);
    chk("rst_bits", {29'h0, fq, tq, tqn}, 32'h1);
    i_reset_n <= 1'b1;
    rd("rst_cfg", 8'h00, 32'h0);
    tally_and_finish();
  end
endmodule
